// File: verilog/dbfs_pkg.sv
// Shared constants and types for the dual bank flash swap mapping logic.
package dbfs_pkg;

   // Address map of the code flash region.
   localparam logic [31:0] BANK_HI_BASE   = 32'hFFF0_0000; // Execution window, start.
   localparam logic [31:0] BANK_HI_LAST   = 32'hFFFF_FFFF; // Execution window, end.
   localparam logic [31:0] BANK_LO_BASE   = 32'hFFE0_0000; // Lower window, start.
   localparam logic [31:0] BANK_LO_LAST   = 32'hFFEF_FFFF; // Lower window, end.
   localparam int          WIN_SEL_BIT    = 20;            // Selects upper or lower window.
   localparam int          REGION_LSB     = 21;            // Lowest bit of the region tag.
   localparam int          OFFSET_W       = 20;            // Byte offset inside one bank.

   // Option word fields and their erased (reset) values.
   localparam int          SWAP_W         = 3;
   localparam logic [2:0]  SWAP_ERASED    = 3'h7;          // Unswapped default field value.
   localparam logic [2:0]  SWAP_ALL_ZERO  = 3'h0;

   // Bank mode encoding of the option word bit.
   typedef enum logic {
      DBFS_MODE_DUAL   = 1'b0,
      DBFS_MODE_LINEAR = 1'b1
   } dbfs_mode_type;

   // Configuration capture states, Gray coded along the single path.
   typedef enum logic [1:0] {
      DBFS_CFG_WAIT = 2'b00,
      DBFS_CFG_RUN  = 2'b01
   } dbfs_cfg_type;

   // Result of one address translation.
   typedef struct packed {
      logic                hit;
      logic                bank;
      logic [OFFSET_W-1:0] offset;
   } dbfs_map_type;

endpackage : dbfs_pkg

// File: verilog/dbfs_win_dec.sv
// Registered address window decoder that maps a bus address to a physical bank.
`timescale 1ns/1ps
module dbfs_win_dec #(
   parameter bit EXEC_PORT = 1'b1
) (
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire logic                  req,
   input  wire logic [31:0]           addr,
   input  wire logic                  dual,
   input  wire logic                  swapped,
   output      logic                  ack,
   output      dbfs_pkg::dbfs_map_type map
);

   logic                   ack_reg;
   logic                   ack_next;
   dbfs_pkg::dbfs_map_type map_reg;
   dbfs_pkg::dbfs_map_type map_next;
   logic                   in_region;
   logic                   upper;

   // Translate the address; the execution port sees only the upper window in dual mode.
   always_comb begin
      in_region = (addr[31:dbfs_pkg::REGION_LSB]
                   == dbfs_pkg::BANK_LO_BASE[31:dbfs_pkg::REGION_LSB]);
      upper     = addr[dbfs_pkg::WIN_SEL_BIT];
      ack_next  = req;
      map_next  = '0;
      if (req) begin
         map_next.hit    = in_region && (!EXEC_PORT || !dual || upper);
         map_next.bank   = (~upper) ^ (dual & swapped);
         map_next.offset = addr[dbfs_pkg::OFFSET_W-1:0];
      end
   end

   // Register the answer so that it appears one cycle after the request.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
         map_reg <= '0;
      end else begin
         ack_reg <= ack_next;
         map_reg <= map_next;
      end
   end

   assign ack = ack_reg;
   assign map = map_reg;

endmodule : dbfs_win_dec

// File: verilog/dbfs_top.sv
// Dual bank flash swap: option capture at reset and address mapping for fetch and commands.
// Notes on behaviour
// - Bank mode is either linear or dual.
// - Dual mode splits user flash into two banks.
// - Unswapped: bank 0 high, bank 1 low.
// - Non-erased swap field exchanges banks after reset.
// - Command window moves together with the swap.
// - Field 000b puts command bank 0 low.
// - Linear mode ignores the swap field entirely.
// - Dual mode executes from half the capacity.
// - Unchanged field keeps the previous mapping.
// - Active bank code may program other bank.
`timescale 1ns/1ps
module dbfs_top (
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   opt_bank_mode,
   input  wire logic [2:0]             startup_bank_swap_field,
   input  wire logic                   fetch_req,
   input  wire logic [31:0]            fetch_addr,
   input  wire logic                   cmd_req,
   input  wire logic [31:0]            cmd_addr,
   output      logic                   cfg_ready,
   output      logic                   cfg_dual,
   output      logic                   cfg_swapped,
   output      logic                   fetch_ack,
   output      dbfs_pkg::dbfs_map_type fetch_map,
   output      logic                   cmd_ack,
   output      dbfs_pkg::dbfs_map_type cmd_map,
   output      logic                   cmd_on_active
);

   dbfs_pkg::dbfs_cfg_type cfg_state_reg;
   dbfs_pkg::dbfs_cfg_type cfg_state_next;
   logic                   dual_reg;
   logic                   dual_next;
   logic [2:0]             swap_field_reg;
   logic [2:0]             swap_field_next;
   logic                   swapped_reg;
   logic                   swapped_next;
   logic                   active_reg;
   logic                   active_next;
   logic                   fetch_go;
   logic                   cmd_go;
   logic                   cmd_in_region;

   // Capture the option word once, at the first edge after reset release.
   always_comb begin
      cfg_state_next  = cfg_state_reg;
      dual_next       = dual_reg;
      swap_field_next = swap_field_reg;
      swapped_next    = swapped_reg;
      unique case (cfg_state_reg)
         dbfs_pkg::DBFS_CFG_WAIT: begin
            cfg_state_next  = dbfs_pkg::DBFS_CFG_RUN;
            dual_next       = (opt_bank_mode == dbfs_pkg::DBFS_MODE_DUAL);
            swap_field_next = startup_bank_swap_field;
            // In dual mode, any value other than the erased one selects the exchanged map.
            swapped_next    = (opt_bank_mode == dbfs_pkg::DBFS_MODE_DUAL)
                              && (startup_bank_swap_field != dbfs_pkg::SWAP_ERASED);
         end
         dbfs_pkg::DBFS_CFG_RUN: begin
            cfg_state_next  = dbfs_pkg::DBFS_CFG_RUN;
         end
         default: begin
            cfg_state_next  = dbfs_pkg::DBFS_CFG_WAIT;
         end
      endcase
   end

   // Hold the captured configuration until the next reset.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_state_reg  <= dbfs_pkg::DBFS_CFG_WAIT;
         dual_reg       <= 1'b0;
         swap_field_reg <= dbfs_pkg::SWAP_ERASED;
         swapped_reg    <= 1'b0;
      end else begin
         cfg_state_reg  <= cfg_state_next;
         dual_reg       <= dual_next;
         swap_field_reg <= swap_field_next;
         swapped_reg    <= swapped_next;
      end
   end

   // Requests are ignored until the configuration has been captured.
   assign fetch_go      = fetch_req && (cfg_state_reg == dbfs_pkg::DBFS_CFG_RUN);
   assign cmd_go        = cmd_req && (cfg_state_reg == dbfs_pkg::DBFS_CFG_RUN);
   assign cmd_in_region = (cmd_addr[31:dbfs_pkg::REGION_LSB]
                           == dbfs_pkg::BANK_LO_BASE[31:dbfs_pkg::REGION_LSB]);

   // Flag commands that target the bank currently executing; the other bank stays writable.
   always_comb begin
      active_next = 1'b0;
      if (cmd_go) begin
         active_next = dual_reg && cmd_in_region && cmd_addr[dbfs_pkg::WIN_SEL_BIT];
      end
   end

   // Register the active bank flag alongside the command answer.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= active_next;
      end
   end

   // Instruction fetch decoder, limited to the execution window in dual mode.
   dbfs_win_dec #(
      .EXEC_PORT (1'b1)
   ) u_fetch_dec (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .req     (fetch_go),
      .addr    (fetch_addr),
      .dual    (dual_reg),
      .swapped (swapped_reg),
      .ack     (fetch_ack),
      .map     (fetch_map)
   );

   // Command decoder, which reaches both banks and follows the same swap.
   dbfs_win_dec #(
      .EXEC_PORT (1'b0)
   ) u_cmd_dec (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .req     (cmd_go),
      .addr    (cmd_addr),
      .dual    (dual_reg),
      .swapped (swapped_reg),
      .ack     (cmd_ack),
      .map     (cmd_map)
   );

   // Configuration outputs come straight from the capture registers.
   assign cfg_ready     = (cfg_state_reg == dbfs_pkg::DBFS_CFG_RUN);
   assign cfg_dual      = dual_reg;
   assign cfg_swapped   = swapped_reg;
   assign cmd_on_active = active_reg;

   // Checks on the mapping behaviour.
   default clocking dbfs_cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_cfg_hold_stable: assert property (
      cfg_ready |=> cfg_ready && $stable(dual_reg) && $stable(swap_field_reg)
                    && $stable(swapped_reg))
      else $error("Captured configuration changed before reset.");

   a_linear_no_swap: assert property (
      !cfg_dual |-> !cfg_swapped)
      else $error("Linear mode shows an exchanged map.");

   a_swap_from_field: assert property (
      cfg_ready |-> (cfg_swapped == (cfg_dual && (swap_field_reg != dbfs_pkg::SWAP_ERASED))))
      else $error("Swap state does not follow the captured field.");

   a_exec_half_space: assert property (
      fetch_go && cfg_dual && !fetch_addr[dbfs_pkg::WIN_SEL_BIT]
      |=> fetch_ack && !fetch_map.hit)
      else $error("Dual mode fetch hit the lower window.");

   a_default_map: assert property (
      fetch_go && !cfg_swapped && (fetch_addr[31:20] == dbfs_pkg::BANK_HI_BASE[31:20])
      |=> fetch_ack && fetch_map.hit && (fetch_map.bank == 1'b0))
      else $error("Unswapped execution window is not bank 0.");

   a_swapped_exec: assert property (
      fetch_go && cfg_swapped && (fetch_addr[31:20] == dbfs_pkg::BANK_HI_BASE[31:20])
      |=> fetch_ack && fetch_map.hit && (fetch_map.bank == 1'b1))
      else $error("Swapped execution window is not bank 1.");

   a_cmd_zero_field: assert property (
      cmd_go && cfg_dual && (swap_field_reg == dbfs_pkg::SWAP_ALL_ZERO)
      && (cmd_addr[31:20] == dbfs_pkg::BANK_LO_BASE[31:20])
      |=> cmd_ack && cmd_map.hit && (cmd_map.bank == 1'b0))
      else $error("Field 000b does not put command bank 0 low.");

   a_cmd_follows_fetch: assert property (
      fetch_go && cmd_go && (fetch_addr[31:20] == cmd_addr[31:20])
      && cmd_in_region && cmd_addr[dbfs_pkg::WIN_SEL_BIT]
      |=> fetch_map.bank == cmd_map.bank)
      else $error("Command window did not move with the swap.");

   a_cmd_other_bank: assert property (
      cmd_go && cfg_dual && cmd_in_region && !cmd_addr[dbfs_pkg::WIN_SEL_BIT]
      |=> cmd_ack && cmd_map.hit && !cmd_on_active)
      else $error("Other bank is not reachable by commands.");

   a_no_early_ack: assert property (
      !cfg_ready |=> !fetch_ack && !cmd_ack)
      else $error("Answer given before configuration capture.");

   c_dual_swapped:  cover property (cfg_ready && cfg_dual && cfg_swapped);
   c_dual_default:  cover property (cfg_ready && cfg_dual && !cfg_swapped);
   c_linear_mode:   cover property (cfg_ready && !cfg_dual);
   c_cmd_active:    cover property (cmd_ack && cmd_on_active);

endmodule : dbfs_top

// File: testbench/dbfs_host_model.sv
// Model of the CPU fetch path and the flash command issuer on the far side.
`timescale 1ns/1ps
module dbfs_host_model (
   input  wire logic                   ref_clk,
   output      logic                   fetch_req,
   output      logic [31:0]            fetch_addr,
   output      logic                   cmd_req,
   output      logic [31:0]            cmd_addr,
   input  wire logic                   fetch_ack,
   input  wire dbfs_pkg::dbfs_map_type fetch_map,
   input  wire logic                   cmd_ack,
   input  wire dbfs_pkg::dbfs_map_type cmd_map,
   input  wire logic                   cmd_on_active
);
   // Idle address lines carry a pattern, so a stale address never looks valid.
   initial begin
      fetch_req  = 1'b0;
      cmd_req    = 1'b0;
      fetch_addr = 32'h5A5A_5A5A;
      cmd_addr   = 32'hA5A5_A5A5;
   end

   // One request, raised after a falling edge and taken at the next rising edge.
   task automatic xfer(input bit is_cmd, input logic [31:0] a, input int gap,
                       output dbfs_pkg::dbfs_map_type m, output logic act, output bit ok);
      ok  = 1'b0;
      m   = '0;
      act = 1'b0;
      repeat (gap + 1) @(negedge ref_clk);
      if (is_cmd) begin
         cmd_req  = 1'b1;
         cmd_addr = a;
      end else begin
         fetch_req  = 1'b1;
         fetch_addr = a;
      end
      // The answer is awaited for a bounded number of cycles.
      for (int i = 0; i < 3 && !ok; i++) begin
         @(negedge ref_clk);
         if (i == 0) begin
            cmd_req    = 1'b0;
            fetch_req  = 1'b0;
            cmd_addr   = ~a;
            fetch_addr = ~a;
         end
         if (is_cmd && cmd_ack === 1'b1) begin
            ok  = 1'b1;
            m   = cmd_map;
            act = cmd_on_active;
         end else if (!is_cmd && fetch_ack === 1'b1) begin
            ok = 1'b1;
            m  = fetch_map;
         end
      end
   endtask : xfer
endmodule : dbfs_host_model

// File: testbench/test_dual_bank_flash_swap.sv
// Self-checking testbench of the bank swap address mapping.
`timescale 1ns/1ps
module test_dual_bank_flash_swap;
   logic                   ref_clk;
   logic                   reset_n;
   logic                   mode;
   logic [2:0]             field;
   logic                   f_req, c_req, f_ack, c_ack, act, rdy, dual, swp;
   logic [31:0]            f_addr, c_addr;
   dbfs_pkg::dbfs_map_type f_map, c_map;
   int                     errors = 0;
   int                     comparisons = 0;

   dbfs_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .opt_bank_mode(mode),
      .startup_bank_swap_field(field), .fetch_req(f_req), .fetch_addr(f_addr),
      .cmd_req(c_req), .cmd_addr(c_addr), .cfg_ready(rdy), .cfg_dual(dual),
      .cfg_swapped(swp), .fetch_ack(f_ack), .fetch_map(f_map), .cmd_ack(c_ack),
      .cmd_map(c_map), .cmd_on_active(act));
   dbfs_host_model host (.ref_clk(ref_clk), .fetch_req(f_req), .fetch_addr(f_addr),
      .cmd_req(c_req), .cmd_addr(c_addr), .fetch_ack(f_ack), .fetch_map(f_map),
      .cmd_ack(c_ack), .cmd_map(c_map), .cmd_on_active(act));

   // A 100 ns clock.
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Resets with the given options held, then checks the captured mode.
   task automatic rst(input logic md, input logic [2:0] fd);
      @(negedge ref_clk);
      reset_n = 1'b0;
      mode    = md;
      field   = fd;
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      chk("cfg_ready", 32'h1, 32'(rdy));
      chk("cfg_dual", 32'(!md), 32'(dual));
      chk("cfg_swapped", 32'(!md && fd != 3'h7), 32'(swp));
   endtask : rst

   // One transfer through the host model, with the expected hit, bank and active flag.
   task automatic ex(input bit c, input logic [31:0] a, input logic h, input logic b,
                     input logic ac, input int gap = 0);
      dbfs_pkg::dbfs_map_type m;
      logic                   at;
      bit                     ok;
      host.xfer(c, a, gap, m, at, ok);
      if (!ok) begin
         errors++;
         $display("MISMATCH ack expected 1 seen 0");
         tally_and_finish();
      end else begin
         chk("hit", 32'(h), 32'(m.hit));
         if (h) chk("bank", 32'(b), 32'(m.bank));
         if (h) chk("offset", 32'(a[19:0]), 32'(m.offset));
         if (c) chk("cmd_on_active", 32'(ac), 32'(at));
      end
   endtask : ex

   // A request raised together with reset release meets the capture edge and is ignored.
   task automatic t_early;
      dbfs_pkg::dbfs_map_type m;
      logic                   at;
      bit                     ok;
      @(negedge ref_clk);
      reset_n = 1'b0;
      mode    = 1'b0;
      field   = 3'h7;
      repeat (5) @(negedge ref_clk);
      fork
         host.xfer(1'b0, 32'hFFF0_0000, 0, m, at, ok);
         begin
            @(negedge ref_clk);
            reset_n = 1'b1;
         end
      join
      chk("early_ack", 32'h0, 32'(ok));
      $display("test early done");
   endtask : t_early

   // Erased field: bank 0 high, bank 1 low, only the high half fetchable.
   task automatic t_unswapped;
      rst(1'b0, 3'h7);
      ex(1'b0, 32'hFFF0_1234, 1'b1, 1'b0, 1'b0);
      ex(1'b0, 32'hFFE0_0010, 1'b0, 1'b0, 1'b0);
      ex(1'b1, 32'hFFEF_FFF0, 1'b1, 1'b1, 1'b0, 3);
      ex(1'b1, 32'hFFFF_FFFC, 1'b1, 1'b0, 1'b1);
      ex(1'b1, 32'h1000_0000, 1'b0, 1'b0, 1'b0);
      $display("test unswapped done");
   endtask : t_unswapped

   // Field 000b swaps fetch and command windows; later field changes are ignored.
   task automatic t_swapped;
      rst(1'b0, 3'h0);
      ex(1'b0, 32'hFFF0_0000, 1'b1, 1'b1, 1'b0);
      ex(1'b1, 32'hFFE0_0000, 1'b1, 1'b0, 1'b0);
      ex(1'b1, 32'hFFF0_0100, 1'b1, 1'b1, 1'b1);
      field = 3'h7;
      ex(1'b0, 32'hFFF0_0008, 1'b1, 1'b1, 1'b0);
      $display("test swapped done");
   endtask : t_swapped

   // Linear mode ignores the swap field and maps by window.
   task automatic t_linear;
      rst(1'b1, 3'h0);
      ex(1'b0, 32'hFFE0_0004, 1'b1, 1'b1, 1'b0);
      ex(1'b0, 32'hFFF0_0004, 1'b1, 1'b0, 1'b0);
      $display("test linear done");
   endtask : t_linear

   // A reset with the field left unchanged keeps the running bank.
   task automatic t_interrupted;
      rst(1'b0, 3'h0);
      rst(1'b0, 3'h0);
      ex(1'b0, 32'hFFF0_0040, 1'b1, 1'b1, 1'b0);
      $display("test interrupted done");
   endtask : t_interrupted

   // Main sequence.
   initial begin
      reset_n = 1'b0;
      mode    = 1'b0;
      field   = 3'h7;
      t_unswapped();
      t_swapped();
      t_linear();
      t_interrupted();
      t_early();
      tally_and_finish();
   end
endmodule : test_dual_bank_flash_swap
